// ### hw/dmairq_channel.sv
// one dma channel: interrupt control word, start address registers, event detection
// assumes pointer, cell count and event inputs come from logic on clk_in
//
// Our own choices: the address-and-strobe port and the register addresses.
`include "dmairq_consts.svh"
`timescale 1ns/10ps
module dmairq_channel (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire dmairq_pkg::dmairq_bus_s     bus_in,
    output logic [31:0]                      rdata_out,
    input  wire logic [15:0]                 src_pointer_in,
    input  wire logic [15:0]                 dst_pointer_in,
    input  wire logic [15:0]                 cell_count_in,
    input  wire logic                        byte_moved_in,
    input  wire logic                        irq_valid_in,
    input  wire logic [7:0]                  irq_number_in,
    input  wire logic                        pattern_match_in,
    input  wire logic                        addr_err_in,
    output logic                             channel_on_out,
    output logic                             abort_out,
    output logic [31:0]                      src_start_addr_out,
    output logic [31:0]                      dst_start_addr_out,
    output logic [15:0]                      src_size_out,
    output logic [15:0]                      dst_size_out,
    output logic [15:0]                      cell_size_out,
    output logic                             channel_irq_out
);
    // ==========================================================
    // registers
    logic [7:0]              irq_en_r;
    dmairq_pkg::dmairq_ev_s  flags_r;
    dmairq_pkg::dmairq_ev_s  flags_nxt;
    dmairq_pkg::dmairq_ev_s  ev;
    logic [31:0]             src_start_addr_r;
    logic [31:0]             dst_start_addr_r;
    logic [7:0]              abort_irq_number_r;
    logic                    pattern_abort_en_r;
    logic                    abort_on_irq_en_r;
    logic                    channel_on_r;
    logic [15:0]             src_size_r;
    logic [15:0]             dst_size_r;
    logic [15:0]             cell_size_r;
    logic [16:0]             moved_r;
    logic [15:0]             src_ptr_q;
    logic [15:0]             dst_ptr_q;
    logic [31:0]             rdata_r;

    // zero size stands for the full 64 KiB
    function automatic logic [16:0] eff_size(input logic [15:0] s);
        eff_size = (s == 16'h0000) ? `DMAIRQ_SIZE_FULL : {1'b0, s};
    endfunction

    logic wr_int;
    logic wr_ssa;
    logic wr_dsa;
    logic wr_evt;
    logic wr_size;
    logic wr_cell;
    assign wr_int  = bus_in.wr && (bus_in.addr == `DMAIRQ_OFF_INT);
    assign wr_ssa  = bus_in.wr && (bus_in.addr == `DMAIRQ_OFF_SSA);
    assign wr_dsa  = bus_in.wr && (bus_in.addr == `DMAIRQ_OFF_DSA);
    assign wr_evt  = bus_in.wr && (bus_in.addr == `DMAIRQ_OFF_EVT);
    assign wr_size = bus_in.wr && (bus_in.addr == `DMAIRQ_OFF_SIZE);
    assign wr_cell = bus_in.wr && (bus_in.addr == `DMAIRQ_OFF_CELL);

    // ==========================================================
    // event detection
    logic [16:0] s_eff;
    logic [16:0] d_eff;
    logic [16:0] big;
    logic        abort_hit;
    logic        pat_hit;
    assign s_eff = eff_size(src_size_r);
    assign d_eff = eff_size(dst_size_r);
    assign big   = (s_eff > d_eff) ? s_eff : d_eff;
    // abort only matters while the channel runs
    assign abort_hit = channel_on_r && abort_on_irq_en_r && irq_valid_in
                       && (irq_number_in == abort_irq_number_r);
    assign pat_hit   = channel_on_r && pattern_match_in;

    // pointer compares fire on the change, so a pointer parked at the end does not refire
    always_comb begin
        ev.src_done   = (src_pointer_in != src_ptr_q) && ({1'b0, src_pointer_in} == s_eff);
        ev.src_half   = (src_pointer_in != src_ptr_q)
                        && ({1'b0, src_pointer_in} == (s_eff >> 1));
        ev.dst_done   = (dst_pointer_in != dst_ptr_q) && ({1'b0, dst_pointer_in} == d_eff);
        ev.dst_half   = (dst_pointer_in != dst_ptr_q)
                        && ({1'b0, dst_pointer_in} == (d_eff >> 1));
        ev.block_done = (byte_moved_in && channel_on_r && ((moved_r + 17'h0_0001) == big))
                        || pat_hit;
        ev.cell_done  = byte_moved_in && channel_on_r
                        && ({1'b0, cell_count_in} == eff_size(cell_size_r));
        ev.abort      = abort_hit;
        ev.addr_err   = addr_err_in;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            src_ptr_q <= 16'h0000;
            dst_ptr_q <= 16'h0000;
        end else begin
            src_ptr_q <= src_pointer_in;
            dst_ptr_q <= dst_pointer_in;
        end
    end

    // ==========================================================
    // interrupt control word
    always_comb begin
        flags_nxt = flags_r;
        if (wr_int) begin
            flags_nxt = dmairq_pkg::dmairq_ev_s'(bus_in.wdata[`DMAIRQ_FLAG_MSB:`DMAIRQ_FLAG_LSB]);
        end
        // hardware set wins over a software clear in the same cycle
        flags_nxt = flags_nxt | ev;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags_r  <= dmairq_pkg::dmairq_ev_s'(8'h00);
            irq_en_r <= 8'h00;
        end else begin
            flags_r <= flags_nxt;
            if (wr_int) begin
                irq_en_r <= bus_in.wdata[`DMAIRQ_EN_MSB:`DMAIRQ_EN_LSB];
            end
        end
    end

    assign channel_irq_out = |(irq_en_r & flags_r);

    // ==========================================================
    // start addresses
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            src_start_addr_r <= `DMAIRQ_RST_WORD;
            dst_start_addr_r <= `DMAIRQ_RST_WORD;
        end else begin
            if (wr_ssa) begin
                src_start_addr_r <= bus_in.wdata;
            end
            if (wr_dsa) begin
                dst_start_addr_r <= bus_in.wdata;
            end
        end
    end

    // ==========================================================
    // event control, sizes, channel on
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            abort_irq_number_r <= `DMAIRQ_RST_AIRQ;
            pattern_abort_en_r <= 1'b0;
            abort_on_irq_en_r  <= 1'b0;
            channel_on_r       <= 1'b0;
        end else begin
            if (wr_evt) begin
                abort_irq_number_r <= bus_in.wdata[`DMAIRQ_AIRQ_MSB:`DMAIRQ_AIRQ_LSB];
                pattern_abort_en_r <= bus_in.wdata[`DMAIRQ_PATTERN_ABORT_EN_BIT];
                abort_on_irq_en_r  <= bus_in.wdata[`DMAIRQ_ABORT_ON_IRQ_EN_BIT];
                channel_on_r       <= bus_in.wdata[`DMAIRQ_CHON_BIT];
            end
            // ending the transfer overrides a simultaneous enable write
            if (abort_hit || (pat_hit && pattern_abort_en_r) || ev.block_done) begin
                channel_on_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            src_size_r  <= 16'h0000;
            dst_size_r  <= 16'h0000;
            cell_size_r <= 16'h0000;
        end else begin
            if (wr_size) begin
                src_size_r <= bus_in.wdata[15:0];
                dst_size_r <= bus_in.wdata[31:16];
            end
            if (wr_cell) begin
                cell_size_r <= bus_in.wdata[15:0];
            end
        end
    end

    // byte count toward block completion, restarts when the channel is off
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            moved_r <= 17'h0_0000;
        end else if (!channel_on_r || ev.block_done) begin
            moved_r <= 17'h0_0000;
        end else if (byte_moved_in) begin
            moved_r <= moved_r + 17'h0_0001;
        end
    end

    // ==========================================================
    // read port, data one cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_r <= 32'h0000_0000;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                `DMAIRQ_OFF_INT:  rdata_r <= {8'h00, irq_en_r, 8'h00, flags_r};
                `DMAIRQ_OFF_SSA:  rdata_r <= src_start_addr_r;
                `DMAIRQ_OFF_DSA:  rdata_r <= dst_start_addr_r;
                `DMAIRQ_OFF_EVT:  rdata_r <= {8'h00, abort_irq_number_r, 8'h00, channel_on_r, 1'b0,
                                              pattern_abort_en_r, 1'b0, abort_on_irq_en_r, 3'h0};
                `DMAIRQ_OFF_SIZE: rdata_r <= {dst_size_r, src_size_r};
                `DMAIRQ_OFF_CELL: rdata_r <= {16'h0000, cell_size_r};
                default:          rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign rdata_out          = rdata_r;
    assign channel_on_out     = channel_on_r;
    assign abort_out          = abort_hit;
    // software is trusted to have written physical addresses here
    assign src_start_addr_out = src_start_addr_r;
    assign dst_start_addr_out = dst_start_addr_r;
    assign src_size_out       = src_size_r;
    assign dst_size_out       = dst_size_r;
    assign cell_size_out      = cell_size_r;

    // ==========================================================
    // checks
    a_irq_output: assert property (@(posedge clk_in) disable iff (rst_in)
        channel_irq_out == |(irq_en_r & flags_r)) else $error("irq output mismatch");
    a_flag_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
        (flags_r.src_done && !wr_int) |=> flags_r.src_done) else $error("flag dropped");
    a_src_done_set: assert property (@(posedge clk_in) disable iff (rst_in)
        ((src_pointer_in != src_ptr_q) && ({1'b0, src_pointer_in} == s_eff)) |=> flags_r.src_done)
        else $error("src done not set");
    a_dst_half_set: assert property (@(posedge clk_in) disable iff (rst_in)
        ((dst_pointer_in != dst_ptr_q) && ({1'b0, dst_pointer_in} == (d_eff >> 1))) |=> flags_r.dst_half)
        else $error("dst half not set");
    a_abort_stop: assert property (@(posedge clk_in) disable iff (rst_in)
        abort_hit |=> (!channel_on_r && flags_r.abort)) else $error("abort not taken");
    a_pattern_stop: assert property (@(posedge clk_in) disable iff (rst_in)
        (pat_hit && pattern_abort_en_r) |=> (!channel_on_r && flags_r.block_done))
        else $error("pattern abort failed");
    a_addr_err_set: assert property (@(posedge clk_in) disable iff (rst_in)
        addr_err_in |=> flags_r.addr_err) else $error("addr error not set");
    a_int_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
        $past(bus_in.rd) && ($past(bus_in.addr) == `DMAIRQ_OFF_INT) |-> (rdata_out[31:24] == 8'h00)
        && (rdata_out[15:8] == 8'h00)) else $error("reserved bits nonzero");
    a_ssa_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_ssa |=> (src_start_addr_r == $past(bus_in.wdata))) else $error("ssa write lost");
    a_zero_size: assert property (@(posedge clk_in) disable iff (rst_in)
        (src_size_r == 16'h0000) |-> (s_eff == 17'h1_0000)) else $error("zero size wrong");

    // ==========================================================
    // event flag, channel stop and abort compare checks
    a_src_half_set: assert property (@(posedge clk_in) disable iff (rst_in)
        ((src_pointer_in != src_ptr_q) && ({1'b0, src_pointer_in} == (s_eff >> 1))) |=> flags_r.src_half)
        else $error("src half not set");

    a_dst_done_set: assert property (@(posedge clk_in) disable iff (rst_in)
        ((dst_pointer_in != dst_ptr_q) && ({1'b0, dst_pointer_in} == d_eff)) |=> flags_r.dst_done)
        else $error("dst done not set");

    a_block_count: assert property (@(posedge clk_in) disable iff (rst_in)
        (byte_moved_in && channel_on_r && ((moved_r + 17'h0_0001) == big)) |=> flags_r.block_done)
        else $error("block done not set");

    // a match without pattern abort still marks the block as done
    a_pattern_flag: assert property (@(posedge clk_in) disable iff (rst_in)
        pat_hit |=> flags_r.block_done)
        else $error("pattern flag not set");

    a_block_stop: assert property (@(posedge clk_in) disable iff (rst_in)
        ev.block_done |=> !channel_on_r)
        else $error("channel left on after block");

    a_cell_done_set: assert property (@(posedge clk_in) disable iff (rst_in)
        (byte_moved_in && channel_on_r && ({1'b0, cell_count_in} == eff_size(cell_size_r))) |=> flags_r.cell_done)
        else $error("cell done not set");

    a_abort_match: assert property (@(posedge clk_in) disable iff (rst_in)
        (irq_valid_in && (irq_number_in != abort_irq_number_r)) |-> !abort_out)
        else $error("abort on wrong irq number");

    // ==========================================================
    // register and read port checks
    a_en_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_int |=> (irq_en_r == $past(bus_in.wdata[`DMAIRQ_EN_MSB:`DMAIRQ_EN_LSB])))
        else $error("enable write lost");

    // only a quiet cycle shows the plain written value, events would add bits
    a_flag_write: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_int && (ev == 8'h00)) |=> (flags_r == $past(bus_in.wdata[`DMAIRQ_FLAG_MSB:`DMAIRQ_FLAG_LSB])))
        else $error("flag write lost");

    a_dsa_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_dsa |=> (dst_start_addr_r == $past(bus_in.wdata)))
        else $error("dsa write lost");

    a_ssa_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !wr_ssa |=> $stable(src_start_addr_r))
        else $error("ssa changed without write");

    a_dsa_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !wr_dsa |=> $stable(dst_start_addr_r))
        else $error("dsa changed without write");

    a_int_read: assert property (@(posedge clk_in) disable iff (rst_in)
        ($past(bus_in.rd) && ($past(bus_in.addr) == `DMAIRQ_OFF_INT))
        |-> ((rdata_out[23:16] == $past(irq_en_r)) && (rdata_out[7:0] == $past(flags_r))))
        else $error("int word read wrong");

    a_rdata_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        !$past(bus_in.rd) |-> (rdata_out == 32'h0000_0000))
        else $error("read data outside read cycle");

    // no disable here: the check looks at the first edge after reset lets go
    a_reset_clear: assert property (@(posedge clk_in)
        ($past(rst_in) && !rst_in) |-> ((flags_r == 8'h00) && (irq_en_r == 8'h00)
        && (src_start_addr_r == 32'h0000_0000) && (dst_start_addr_r == 32'h0000_0000)))
        else $error("state not cleared by reset");

    c_irq_fire: cover property (@(posedge clk_in) disable iff (rst_in) $rose(channel_irq_out));
    c_block_done: cover property (@(posedge clk_in) disable iff (rst_in) ev.block_done && !pat_hit);
    c_abort: cover property (@(posedge clk_in) disable iff (rst_in) abort_hit);
    c_pattern: cover property (@(posedge clk_in) disable iff (rst_in) pat_hit && pattern_abort_en_r);
    c_set_clear: cover property (@(posedge clk_in) disable iff (rst_in) wr_int && (ev != 8'h00));
endmodule

// ### hw/dmairq_consts.svh
// register offsets, field positions, reset values and sizes for the dma channel irq block
// assumes a word-addressed plain register port with byte offsets
`ifndef DMAIRQ_CONSTS_SVH
`define DMAIRQ_CONSTS_SVH
`define DMAIRQ_ADDR_W       8
`define DMAIRQ_OFF_INT      8'h00
`define DMAIRQ_OFF_SSA      8'h04
`define DMAIRQ_OFF_DSA      8'h08
`define DMAIRQ_OFF_EVT      8'h0c
`define DMAIRQ_OFF_SIZE     8'h10
`define DMAIRQ_OFF_CELL     8'h14
`define DMAIRQ_EN_LSB       16
`define DMAIRQ_EN_MSB       23
`define DMAIRQ_FLAG_LSB     0
`define DMAIRQ_FLAG_MSB     7
`define DMAIRQ_AIRQ_LSB     16
`define DMAIRQ_AIRQ_MSB     23
`define DMAIRQ_PATTERN_ABORT_EN_BIT    5
`define DMAIRQ_ABORT_ON_IRQ_EN_BIT   3
`define DMAIRQ_CHON_BIT     7
`define DMAIRQ_RST_WORD     32'h0000_0000
`define DMAIRQ_RST_AIRQ     8'hff
`define DMAIRQ_SIZE_W       16
`define DMAIRQ_SIZE_FULL    17'h1_0000
`define DMAIRQ_NEV          8
`endif

// ### hw/dmairq_pkg.sv
// types shared by the dma channel irq block
// assumes the constants header is included by users as needed
package dmairq_pkg;
    typedef struct packed {
        logic src_done;
        logic src_half;
        logic dst_done;
        logic dst_half;
        logic block_done;
        logic cell_done;
        logic abort;
        logic addr_err;
    } dmairq_ev_s;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dmairq_bus_s;
endpackage

// ### sim/dmairq_mover.sv
// far-side byte mover: walks both pointers one byte per cycle while go is high
// assumes the channel samples pointers and the byte pulse on clk_in
`timescale 1ns/10ps
module dmairq_mover #(
    parameter int CELL = 2
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        go_in,
    output logic [15:0]      src_pointer_out,
    output logic [15:0]      dst_pointer_out,
    output logic [15:0]      cell_count_out,
    output logic             byte_moved_out
);
    // =========================================
    // pointers and cell count move with the pulse
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            src_pointer_out <= 16'h0;
            dst_pointer_out <= 16'h0;
            cell_count_out  <= 16'h0;
            byte_moved_out  <= 1'b0;
        end else begin
            byte_moved_out <= go_in;
            if (go_in) begin
                src_pointer_out <= src_pointer_out + 16'h1;
                dst_pointer_out <= dst_pointer_out + 16'h1;
                cell_count_out  <= (cell_count_out == 16'(CELL)) ? 16'h1 : cell_count_out + 16'h1;
            end
        end
    end
endmodule

// ### sim/tb_dmairq_channel.sv
// self-checking bench for the dma channel irq and start address block
// assumes the mover model on the pointer side and a plain register port
`include "dmairq_consts.svh"
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_dmairq_channel;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic go = 1'b0;
    logic irq_valid = 1'b0;
    logic [7:0] irq_num = 8'h0;
    logic pmatch = 1'b0;
    logic aerr = 1'b0;
    dmairq_pkg::dmairq_bus_s bus = '0;
    logic [31:0] rdata;
    logic [15:0] sptr, dptr, ccnt;
    logic moved, chon, abort, irq;
    logic [31:0] ssa, dsa;
    logic [15:0] ssz, dsz, csz;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    always #10 clk_in = ~clk_in;
    dmairq_mover #(.CELL(2)) u_mover (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
        .src_pointer_out(sptr), .dst_pointer_out(dptr), .cell_count_out(ccnt), .byte_moved_out(moved));
    dmairq_channel u_dut (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata),
        .src_pointer_in(sptr), .dst_pointer_in(dptr), .cell_count_in(ccnt), .byte_moved_in(moved),
        .irq_valid_in(irq_valid), .irq_number_in(irq_num), .pattern_match_in(pmatch),
        .addr_err_in(aerr), .channel_on_out(chon), .abort_out(abort), .src_start_addr_out(ssa),
        .dst_start_addr_out(dsa), .src_size_out(ssz), .dst_size_out(dsz), .cell_size_out(csz),
        .channel_irq_out(irq));
    // =========================================
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        // the whole sequence needs well under a thousand cycles
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end
    // =========================================
    // scenarios
    task automatic t_regs();
        logic [31:0] d;
        rd(`DMAIRQ_OFF_INT, d); `CHK(d, 32'h0)
        rd(`DMAIRQ_OFF_SSA, d); `CHK(d, 32'h0)
        rd(`DMAIRQ_OFF_DSA, d); `CHK(d, 32'h0)
        wr(`DMAIRQ_OFF_SSA, 32'h1234_5678);
        wr(`DMAIRQ_OFF_DSA, 32'hfedc_ba98);
        wr(8'h3c, 32'hffff_ffff);
        rd(8'h3c, d); `CHK(d, 32'h0)
        rd(`DMAIRQ_OFF_SSA, d); `CHK(d, 32'h1234_5678)
        rd(`DMAIRQ_OFF_DSA, d); `CHK(d, 32'hfedc_ba98)
        `CHK(ssa, 32'h1234_5678)
        `CHK(dsa, 32'hfedc_ba98)
        wr(`DMAIRQ_OFF_INT, 32'hffff_ffff);
        rd(`DMAIRQ_OFF_INT, d); `CHK(d, 32'h00ff_00ff)
        `CHK(irq, 1'b1)
        wr(`DMAIRQ_OFF_INT, 32'h0);
        rd(`DMAIRQ_OFF_INT, d); `CHK(d, 32'h0)
    endtask
    task automatic t_transfer();
        logic [31:0] d;
        wr(`DMAIRQ_OFF_SIZE, 32'h0008_0004);
        wr(`DMAIRQ_OFF_CELL, 32'h0000_0002);
        wr(`DMAIRQ_OFF_EVT, 32'h0000_0080);
        `CHK(ssz, 16'h0004)
        `CHK(dsz, 16'h0008)
        `CHK(csz, 16'h0002)
        @(posedge clk_in);
        go <= 1'b1;
        repeat (8) @(posedge clk_in);
        go <= 1'b0;
        repeat (3) @(posedge clk_in);
        rd(`DMAIRQ_OFF_INT, d);
        `CHK(d[7:4], 4'hf)
        `CHK(d[3:2], 2'h3)
        `CHK(d[1:0], 2'h0)
        `CHK(chon, 1'b0)
        `CHK(irq, 1'b0)
        wr(`DMAIRQ_OFF_INT, 32'h0004_00fc);
        `CHK(irq, 1'b1)
        wr(`DMAIRQ_OFF_INT, 32'h0004_00f8);
        `CHK(irq, 1'b0)
        rd(`DMAIRQ_OFF_INT, d); `CHK(d, 32'h0004_00f8)
        wr(`DMAIRQ_OFF_INT, 32'h0);
    endtask
    task automatic t_abort();
        logic [31:0] d;
        wr(`DMAIRQ_OFF_EVT, 32'h0021_0088);
        // a near-miss number first, so an ignored compare shows up
        @(posedge clk_in);
        irq_num <= 8'h20;
        irq_valid <= 1'b1;
        #1;
        `CHK(abort, 1'b0)
        @(posedge clk_in);
        irq_num <= 8'h21;
        #1;
        `CHK(abort, 1'b1)
        @(posedge clk_in);
        irq_valid <= 1'b0;
        rd(`DMAIRQ_OFF_INT, d); `CHK(d, 32'h0000_0002)
        wr(`DMAIRQ_OFF_INT, 32'h0);
        @(posedge clk_in);
        aerr <= 1'b1;
        @(posedge clk_in);
        aerr <= 1'b0;
        rd(`DMAIRQ_OFF_INT, d); `CHK(d, 32'h0000_0001)
        wr(`DMAIRQ_OFF_INT, 32'h0);
    endtask
    task automatic t_pattern();
        logic [31:0] d;
        wr(`DMAIRQ_OFF_EVT, 32'h0000_00a0);
        `CHK(chon, 1'b1)
        @(posedge clk_in);
        pmatch <= 1'b1;
        @(posedge clk_in);
        pmatch <= 1'b0;
        rd(`DMAIRQ_OFF_INT, d); `CHK(d, 32'h0000_0008)
        `CHK(chon, 1'b0)
    endtask
    task automatic t_reset();
        logic [31:0] d;
        wr(`DMAIRQ_OFF_INT, 32'h00ff_0040);
        wr(`DMAIRQ_OFF_SSA, 32'h0000_0abc);
        `CHK(irq, 1'b1)
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(`DMAIRQ_OFF_INT, d); `CHK(d, 32'h0)
        rd(`DMAIRQ_OFF_SSA, d); `CHK(d, 32'h0)
        `CHK(irq, 1'b0)
        `CHK(ssa, 32'h0)
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_transfer();
        t_abort();
        t_pattern();
        t_reset();
        test_done();
    end
endmodule
